// *** logic/fepd_core.sv ***
// erase, deep sleep, wake and id-read command handling of a serial flash
// assumes the array, status register and write enable live outside;
// link logic runs on sclk_i, timers on sys_clk_i
`timescale 1ns/1ns
`include "fepd_consts.svh"

// Contract
// - D8 plus three address bytes erases block.
// - erase needs write latch flag set.
// - block erase needs select rise after 32 bits.
// - erase starts at select rise, busy flag meanwhile.
// - erase clears write latch flag before finishing.
// - protected target block refuses block erase.
// - 60 or C7 alone, exactly eight bits.
// - chip erase only when nothing protected.
// - B9 alone enters sleep after entry delay.
// - asleep, only wake command is honoured.
// - sleep command rejected while cycle busy.
// - select high and idle means standby.
// - reset always lands in standby.
// - AB alone wakes; nothing accepted until delay.
// - AB plus dummies streams device id.
// - wake/id ignored while busy flag set.
// - 90 with address zero: maker, then device.
// - address one swaps id order.
// - 92 reads ids over two lines.
// - 94 reads ids over four lines.
// - inputs sampled on rising link clock.
module fepd_core #(
  parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'h3C, // arbitrary value
  parameter int unsigned BLOCK_ERASE_CYC =
    `FEPD_BLOCK_ERASE_MS * 1000000 / `FEPD_SYS_CLK_NS,
  parameter int unsigned FULL_ERASE_CYC =
    `FEPD_FULL_ERASE_MS * 1000000 / `FEPD_SYS_CLK_NS
) (
  // system clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // serial link
  input wire logic sclk_i,
  input wire logic cs_b_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o,
  // status from the rest of the flash
  input wire logic write_latch_flag_i,
  input wire logic [4:0] block_protect_bits_i,
  input wire logic other_busy_i,
  input wire logic boost_mode_i,
  // status and actions to the rest of the flash
  output logic write_in_progress_flag_o,
  output logic write_latch_clr_o,
  output logic boost_release_o,
  output logic erase_go_o,
  output logic erase_chip_o,
  output logic [1:0] erase_block_o,
  output logic standby_o,
  output logic deep_sleep_o
);
  localparam logic [31:0] SLEEP_CYC = 32'((`FEPD_SLEEP_ENTRY_NS + `FEPD_SYS_CLK_NS - 1)
    / `FEPD_SYS_CLK_NS);
  localparam logic [31:0] WAKE_SHORT_CYC = 32'((`FEPD_WAKE_SHORT_NS + `FEPD_SYS_CLK_NS - 1)
    / `FEPD_SYS_CLK_NS);
  localparam logic [31:0] WAKE_ID_CYC = 32'((`FEPD_WAKE_ID_NS + `FEPD_SYS_CLK_NS - 1)
    / `FEPD_SYS_CLK_NS);
  localparam logic [31:0] BLK_CYC = 32'(BLOCK_ERASE_CYC);
  localparam logic [31:0] CHIP_CYC = 32'(FULL_ERASE_CYC);

  // address phase end per opcode, in rising edges from select low
  function automatic logic [7:0] addr_end(input logic [7:0] op);
    unique case (op)
      `FEPD_OP_ID_X2: addr_end = `FEPD_CNT_ADDR_X2;
      `FEPD_OP_ID_X4: addr_end = `FEPD_CNT_ADDR_X4;
      default: addr_end = `FEPD_CNT_ADDR_X1;
    endcase
  endfunction

  // lanes as a log2 shift: 0 single, 1 dual, 2 quad
  function automatic logic [1:0] lane_log(input logic [7:0] op);
    unique case (op)
      `FEPD_OP_ID_X2: lane_log = 2'h1;
      `FEPD_OP_ID_X4: lane_log = 2'h2;
      default: lane_log = 2'h0;
    endcase
  endfunction

  function automatic logic is_id_read(input logic [7:0] op);
    is_id_read = (op == `FEPD_OP_ID_X1) || (op == `FEPD_OP_ID_X2)
      || (op == `FEPD_OP_ID_X4);
  endfunction

  // protect bits: [4] all, [2:0] block count, [3] counts from bottom
  function automatic logic blk_protected(input logic [4:0] bp, input logic [1:0] blk);
    logic [2:0] n;
    n = (bp[2:0] > `FEPD_BLK_COUNT) ? `FEPD_BLK_COUNT : bp[2:0];
    if (bp[4]) begin
      blk_protected = 1'b1;
    end else if (bp[3]) begin
      blk_protected = {1'b0, blk} < n;
    end else begin
      blk_protected = {1'b0, blk} >= (`FEPD_BLK_COUNT - n);
    end
  endfunction

  // ---------------- link domain ----------------
  fepd_pkg::fepd_link_s lk_q, lk_d;
  logic open_q;
  logic [1:0] lk_stat;
  logic busy_l;
  logic asleep_l;
  fepd_pkg::fepd_pwr_e pwr_q;
  logic busy;

  typedef struct packed {
    logic [3:0] bits;
    logic [3:0] oe;
  } fepd_out_s;
  fepd_out_s out_q, out_d;

  // open_q drops with select, so a frame never sees the previous one's count
  always_ff @(posedge sclk_i or posedge cs_b_i) begin
    if (cs_b_i) begin
      open_q <= 1'b0;
    end else begin
      open_q <= 1'b1;
    end
  end

  fepd_sync #(.W(2)) u_lk_sync (
    .clk_i(sclk_i),
    .rst_b_i(1'b1),
    .d_i({busy, pwr_q != fepd_pkg::PWR_STANDBY}),
    .q_o(lk_stat)
  );
  assign busy_l = lk_stat[1];
  assign asleep_l = lk_stat[0];

  always_comb begin
    logic [7:0] cnt;
    logic [23:0] addr;
    logic [7:0] op;
    cnt = open_q ? lk_q.cnt : 8'h00;
    addr = open_q ? lk_q.addr : 24'h000000;
    op = open_q ? lk_q.op : 8'h00;
    lk_d = lk_q;
    lk_d.tog = open_q ? lk_q.tog : ~lk_q.tog;
    lk_d.cnt = (cnt == `FEPD_CNT_MAX) ? cnt : cnt + 8'h01;
    lk_d.op = op;
    lk_d.addr = addr;
    if (cnt < `FEPD_CNT_OP) begin
      lk_d.op = {op[6:0], io_i[0]};
    end else if (cnt < addr_end(op)) begin
      unique case (lane_log(op))
        2'h1: lk_d.addr = {addr[21:0], io_i[1:0]};
        2'h2: lk_d.addr = {addr[19:0], io_i[3:0]};
        default: lk_d.addr = {addr[22:0], io_i[0]};
      endcase
    end
  end

  // the link clock is idle through reset, so this clear releases safely
  always_ff @(posedge sclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lk_q <= '0;
    end else begin
      lk_q <= lk_d;
    end
  end

  // output word and lane mapping, launched on falling edges
  always_comb begin
    logic [15:0] pat;
    logic [15:0] sh;
    logic [7:0] k;
    logic [7:0] kw;
    logic go;
    go = 1'b0;
    pat = {MAKER_ID, DEVICE_ID};
    if (lk_q.op == `FEPD_OP_WAKE) begin
      go = !busy_l && (lk_q.cnt >= `FEPD_CNT_ADDR_X1);
      pat = {DEVICE_ID, DEVICE_ID};
    end else if (is_id_read(lk_q.op)) begin
      go = !asleep_l && (lk_q.cnt >= addr_end(lk_q.op));
      if (lk_q.addr == `FEPD_ADDR_DEV_FIRST) begin
        pat = {DEVICE_ID, MAKER_ID};
      end
    end
    k = lk_q.cnt - addr_end(lk_q.op);
    kw = k << lane_log(lk_q.op);
    sh = pat << kw[3:0];
    out_d.bits = 4'h0;
    out_d.oe = 4'h0;
    if (go && open_q) begin
      unique case (lane_log(lk_q.op))
        2'h1: begin
          out_d.bits = {2'b00, sh[15:14]};
          out_d.oe = 4'h3;
        end
        2'h2: begin
          out_d.bits = sh[15:12];
          out_d.oe = 4'hF;
        end
        default: begin
          out_d.bits = {2'b00, sh[15], 1'b0};
          out_d.oe = 4'h2;
        end
      endcase
    end
  end

  always_ff @(negedge sclk_i or posedge cs_b_i) begin
    if (cs_b_i) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  assign io_o = out_q.bits;
  assign io_oe_o = out_q.oe & {4{~cs_b_i}};

  // ---------------- system domain ----------------
  typedef struct packed {
    fepd_pkg::fepd_pwr_e pwr;
    logic [31:0] ptmr;
    logic [31:0] etmr;
    logic erun;
    logic echip;
    logic [1:0] eblk;
    logic cs_prev;
    logic tog_seen;
    logic wl_clr;
    logic boost_clr;
    logic go;
  } fepd_sys_s;
  fepd_sys_s sys_q, sys_d;
  logic [1:0] sy_lvl;
  logic cs_s;
  logic tog_s;

  fepd_sync #(.W(2)) u_sys_sync (
    .clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    // select goes in inverted so the reset value matches an idle pin
    .d_i({~cs_b_i, lk_q.tog}),
    .q_o(sy_lvl)
  );
  assign cs_s = ~sy_lvl[1];
  assign tog_s = sy_lvl[0];
  assign pwr_q = sys_q.pwr;
  assign busy = sys_q.erun | other_busy_i;

  // link words are read only after select rose and settled: no sclk edges then
  always_comb begin
    logic fresh;
    logic [7:0] op;
    logic [7:0] cnt;
    sys_d = sys_q;
    sys_d.cs_prev = cs_s;
    sys_d.wl_clr = 1'b0;
    sys_d.boost_clr = 1'b0;
    sys_d.go = 1'b0;
    fresh = cs_s && !sys_q.cs_prev && (tog_s != sys_q.tog_seen);
    op = lk_q.op;
    cnt = lk_q.cnt;
    if (cs_s && !sys_q.cs_prev) begin
      sys_d.tog_seen = tog_s;
    end
    if (sys_q.erun) begin
      sys_d.etmr = sys_q.etmr - 32'h1;
      if (sys_q.etmr == 32'h1) begin
        sys_d.erun = 1'b0;
      end
    end
    unique case (sys_q.pwr)
      fepd_pkg::PWR_STANDBY: begin
        if (fresh && !busy) begin
          if (op == `FEPD_OP_SLEEP && cnt == `FEPD_CNT_OP) begin
            sys_d.pwr = fepd_pkg::PWR_ENTERING;
            sys_d.ptmr = SLEEP_CYC;
            sys_d.boost_clr = boost_mode_i;
          end else if (op == `FEPD_OP_WAKE && cnt == `FEPD_CNT_OP) begin
            sys_d.pwr = fepd_pkg::PWR_WAKING;
            sys_d.ptmr = WAKE_SHORT_CYC;
            sys_d.boost_clr = boost_mode_i;
          end else if (op == `FEPD_OP_BLOCK_ERASE && cnt == `FEPD_CNT_ADDR_X1
              && write_latch_flag_i
              && !blk_protected(block_protect_bits_i, lk_q.addr[17:16])) begin
            sys_d.erun = 1'b1;
            sys_d.echip = 1'b0;
            sys_d.eblk = lk_q.addr[17:16];
            sys_d.etmr = BLK_CYC;
            sys_d.go = 1'b1;
            sys_d.wl_clr = 1'b1;
          end else if ((op == `FEPD_OP_CHIP_ERASE_A || op == `FEPD_OP_CHIP_ERASE_B)
              && cnt == `FEPD_CNT_OP
              && write_latch_flag_i
              && block_protect_bits_i == 5'h00) begin
            sys_d.erun = 1'b1;
            sys_d.echip = 1'b1;
            sys_d.eblk = 2'h0;
            sys_d.etmr = CHIP_CYC;
            sys_d.go = 1'b1;
            sys_d.wl_clr = 1'b1;
          end
        end
      end
      fepd_pkg::PWR_ENTERING: begin
        sys_d.ptmr = sys_q.ptmr - 32'h1;
        if (sys_q.ptmr == 32'h1) begin
          sys_d.pwr = fepd_pkg::PWR_ASLEEP;
        end
      end
      fepd_pkg::PWR_ASLEEP: begin
        if (fresh && op == `FEPD_OP_WAKE) begin
          if (cnt == `FEPD_CNT_OP) begin
            sys_d.pwr = fepd_pkg::PWR_WAKING;
            sys_d.ptmr = WAKE_SHORT_CYC;
          end else if (cnt >= `FEPD_CNT_ADDR_X1) begin
            sys_d.pwr = fepd_pkg::PWR_WAKING;
            sys_d.ptmr = WAKE_ID_CYC;
          end
        end
      end
      fepd_pkg::PWR_WAKING: begin
        // frames arriving here are dropped whole
        sys_d.ptmr = sys_q.ptmr - 32'h1;
        if (sys_q.ptmr == 32'h1) begin
          sys_d.pwr = fepd_pkg::PWR_STANDBY;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      sys_q <= '{pwr: fepd_pkg::PWR_STANDBY, cs_prev: 1'b1, default: '0};
    end else begin
      sys_q <= sys_d;
    end
  end

  assign write_in_progress_flag_o = sys_q.erun;
  assign write_latch_clr_o = sys_q.wl_clr;
  assign boost_release_o = sys_q.boost_clr;
  assign erase_go_o = sys_q.go;
  assign erase_chip_o = sys_q.echip;
  assign erase_block_o = sys_q.eblk;
  assign standby_o = cs_s && !busy && (sys_q.pwr == fepd_pkg::PWR_STANDBY);
  assign deep_sleep_o = sys_q.pwr == fepd_pkg::PWR_ASLEEP;
endmodule // fepd_core

// *** logic/fepd_sync.sv ***
// three-stage level synchroniser with agreement filter
// assumes d is quasi-static against clk_i
`timescale 1ns/1ns
module fepd_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // level in and out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] f1;
    logic [W-1:0] f2;
    logic [W-1:0] f3;
    logic [W-1:0] q;
  } fepd_sync_s;

  fepd_sync_s st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.f1 = d_i;
    st_d.f2 = st_q.f1;
    st_d.f3 = st_q.f2;
    // first stage feeds only the second; a bit moves once two stages agree
    st_d.q = ((st_q.f2 ~^ st_q.f3) & st_q.f2) | (~(st_q.f2 ~^ st_q.f3) & st_q.q);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q_o = st_q.q;
endmodule // fepd_sync

// *** pkg/fepd_consts.svh ***
// constants for the erase, power-down and id command block
// assumes a 100 MHz system clock; times are in their own units
`ifndef FEPD_CONSTS_SVH
`define FEPD_CONSTS_SVH
`define FEPD_OP_BLOCK_ERASE 8'hD8
`define FEPD_OP_CHIP_ERASE_A 8'h60
`define FEPD_OP_CHIP_ERASE_B 8'hC7
`define FEPD_OP_SLEEP 8'hB9
`define FEPD_OP_WAKE 8'hAB
`define FEPD_OP_ID_X1 8'h90
`define FEPD_OP_ID_X2 8'h92
`define FEPD_OP_ID_X4 8'h94
`define FEPD_CNT_OP 8'h08
`define FEPD_CNT_ADDR_X1 8'h20
`define FEPD_CNT_ADDR_X2 8'h14
`define FEPD_CNT_ADDR_X4 8'h0E
`define FEPD_CNT_MAX 8'hFF
`define FEPD_ADDR_MAKER_FIRST 24'h000000
`define FEPD_ADDR_DEV_FIRST 24'h000001
`define FEPD_BLK_COUNT 3'h4
`define FEPD_SYS_CLK_NS 10
`define FEPD_SLEEP_ENTRY_NS 3000
`define FEPD_WAKE_SHORT_NS 3000
`define FEPD_WAKE_ID_NS 8000
`define FEPD_BLOCK_ERASE_MS 500
`define FEPD_FULL_ERASE_MS 1000
`endif

// *** pkg/fepd_pkg.sv ***
// types shared by the command block
// assumes fepd_consts.svh is on the include path
package fepd_pkg;
  typedef enum logic [1:0] {
    PWR_STANDBY,
    PWR_ENTERING,
    PWR_ASLEEP,
    PWR_WAKING
  } fepd_pwr_e;

  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] op;
    logic [23:0] addr;
    logic tog;
  } fepd_link_s;
endpackage

// *** testbench/fepd_core_asserts.sv ***
// concurrent checks on the erase, sleep and id command block
// assumes it is bound to fepd_core; all checks on the system clock
`timescale 1ns/1ns
module fepd_core_asserts (
  // clock, reset and select
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic cs_b_i,
  // status in
  input wire logic write_latch_flag_i,
  input wire logic [4:0] block_protect_bits_i,
  // outputs watched
  input wire logic [3:0] io_oe_o,
  input wire logic write_in_progress_flag_o,
  input wire logic write_latch_clr_o,
  input wire logic erase_go_o,
  input wire logic erase_chip_o,
  input wire logic standby_o,
  input wire logic deep_sleep_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  chk_go_needs_latch: assert property (erase_go_o |-> write_latch_flag_i)
    else $error("erase began without the write latch");
  chk_go_sets_busy: assert property (erase_go_o |-> ##[0:1] write_in_progress_flag_o)
    else $error("busy flag missing after erase start");
  chk_busy_has_cause: assert property ($rose(write_in_progress_flag_o) |->
    erase_go_o || $past(erase_go_o))
    else $error("busy flag rose with no erase start");
  chk_go_clears_latch: assert property (erase_go_o |-> ##[0:1] write_latch_clr_o)
    else $error("write latch not cleared by erase");
  chk_chip_unprotected: assert property (erase_go_o ##1 erase_chip_o |->
    block_protect_bits_i == 5'h00)
    else $error("chip erase under protection");
  chk_sleep_not_busy: assert property (deep_sleep_o |-> !write_in_progress_flag_o)
    else $error("asleep while erasing");
  chk_asleep_no_erase: assert property (deep_sleep_o |-> !erase_go_o)
    else $error("erase started while asleep");
  chk_standby_idle: assert property (standby_o |->
    !deep_sleep_o && !write_in_progress_flag_o)
    else $error("standby while busy or asleep");
  chk_reset_standby: assert property ($rose(rst_b_i) |->
    !deep_sleep_o && !write_in_progress_flag_o)
    else $error("reset did not land in standby");
  chk_oe_needs_select: assert property (cs_b_i |-> io_oe_o == 4'h0)
    else $error("data driven while deselected");
  chk_oe_lane_set: assert property ((io_oe_o == 4'h0) || (io_oe_o == 4'h2)
    || (io_oe_o == 4'h3) || (io_oe_o == 4'hF))
    else $error("illegal set of driven data lines");
endmodule // fepd_core_asserts

// *** testbench/fepd_core_bench.sv ***
// self-checking bench for the erase, sleep and id command block
// assumes fepd_host drives the link; erase counts shortened
`timescale 1ns/1ns
module fepd_core_bench;
  localparam int BE = 200;
  localparam int CE = 400;
  localparam logic [7:0] MK = 8'h5A; // arbitrary value
  localparam logic [7:0] DV = 8'h3C; // arbitrary value
  logic sys_clk_i = 1'b0;
  logic rst_b_i;
  logic write_latch_flag = 1'b0;
  logic [4:0] bp = 5'h00;
  logic busy = 1'b0;
  logic boost = 1'b0;
  logic sclk;
  logic cs_b;
  logic [3:0] io_i;
  logic [3:0] io_o;
  logic [3:0] io_oe_o;
  logic write_in_progress_flag;
  logic clr;
  logic brel;
  logic go;
  logic chip;
  logic stby;
  logic slp;
  logic [1:0] blk;
  logic [31:0] rd;
  logic oe_seen = 1'b0;
  int fails = 0;
  int checks = 0;
  int gos = 0;
  int boosts = 0;
  int busy_n = 0;
  int clrs = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  fepd_host fepd_host_inst (.sclk_o(sclk), .cs_b_o(cs_b), .io_o(io_i), .dev_io_i(io_o),
    .dev_oe_i(io_oe_o));
  fepd_core #(.MAKER_ID(MK), .DEVICE_ID(DV), .BLOCK_ERASE_CYC(BE), .FULL_ERASE_CYC(CE))
    fepd_core_inst (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .sclk_i(sclk), .cs_b_i(cs_b),
    .io_i(io_i), .io_o(io_o), .io_oe_o(io_oe_o), .write_latch_flag_i(write_latch_flag),
    .block_protect_bits_i(bp), .other_busy_i(busy), .boost_mode_i(boost),
    .write_in_progress_flag_o(write_in_progress_flag), .write_latch_clr_o(clr), .boost_release_o(brel),
    .erase_go_o(go), .erase_chip_o(chip), .erase_block_o(blk), .standby_o(stby),
    .deep_sleep_o(slp));
  always @(posedge sys_clk_i) begin
    if (go === 1'b1) gos <= gos + 1;
    if (brel === 1'b1) boosts <= boosts + 1;
    if (write_in_progress_flag === 1'b1) busy_n <= busy_n + 1;
    if (clr === 1'b1) clrs <= clrs + 1;
  end
  always @(posedge sclk) if (io_oe_o !== 4'h0) oe_seen = 1'b1;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic setin(input logic l, input logic [4:0] p, input logic b, input logic h);
    @(posedge sys_clk_i);
    write_latch_flag <= l;
    bp <= p;
    busy <= b;
    boost <= h;
    ticks(2);
  endtask
  task automatic send(input logic [7:0] op, input logic [23:0] a, input int nab, input int w,
      input int nrd);
    fepd_host_inst.frame(op, a, nab, w, nrd, rd);
    ticks(10);
  endtask
  task automatic go_after(input logic [7:0] op, input logic [23:0] a, input int nab, input int e);
    int g0;
    int c0;
    g0 = gos;
    c0 = clrs;
    send(op, a, nab, 1, 0);
    chk("erase start", e, gos - g0);
    chk("latch clear", e, clrs - c0);
  endtask
  task automatic drain(input int b0, input int d);
    int k;
    for (k = 0; k < 1000 && write_in_progress_flag !== 1'b0; k++) ticks(1);
    chk("erase time", 1, (busy_n - b0 >= d - 1) && (busy_n - b0 <= d + 1));
  endtask
  task automatic t_block();
    int b0;
    setin(1'b1, 5'h00, 1'b0, 1'b0);
    b0 = busy_n;
    go_after(8'hD8, 24'h02ABCD, 24, 1);
    chk("block index", 2, blk);
    chk("block erase not chip", 0, chip);
    drain(b0, BE);
  endtask
  task automatic t_busy();
    setin(1'b1, 5'h00, 1'b1, 1'b0);
    send(8'hB9, 24'h0, 0, 1, 0);
    ticks(320);
    chk("sleep while busy", 0, slp);
    oe_seen = 1'b0;
    send(8'hAB, 24'h0, 24, 1, 8);
    chk("id while busy", 0, oe_seen);
    setin(1'b1, 5'h00, 1'b0, 1'b0);
  endtask
  task automatic t_refuse();
    int b0;
    setin(1'b0, 5'h00, 1'b0, 1'b0);
    go_after(8'hD8, 24'h010000, 24, 0);
    setin(1'b1, 5'h00, 1'b0, 1'b0);
    go_after(8'hD8, 24'h010000, 23, 0);
    go_after(8'h60, 24'h0, 1, 0);
    setin(1'b1, 5'h01, 1'b0, 1'b0);
    go_after(8'hD8, 24'h03FFFF, 24, 0);
    go_after(8'hC7, 24'h0, 0, 0);
    b0 = busy_n;
    go_after(8'hD8, 24'h000000, 24, 1);
    drain(b0, BE);
  endtask
  task automatic t_chip();
    int i;
    int b0;
    setin(1'b1, 5'h00, 1'b0, 1'b0);
    for (i = 0; i < 2; i++) begin
      b0 = busy_n;
      go_after(i ? 8'hC7 : 8'h60, 24'h0, 0, 1);
      chk("chip flag", 1, chip);
      drain(b0, CE);
    end
  endtask
  task automatic t_sleep();
    int b0;
    setin(1'b1, 5'h00, 1'b0, 1'b1);
    b0 = boosts;
    send(8'hB9, 24'h0, 0, 1, 0);
    chk("boost release", 1, boosts - b0);
    setin(1'b1, 5'h00, 1'b0, 1'b0);
    ticks(225);
    chk("asleep early", 0, slp);
    ticks(70);
    chk("asleep", 1, slp);
    go_after(8'hD8, 24'h010000, 24, 0);
    oe_seen = 1'b0;
    send(8'h90, 24'h0, 24, 1, 16);
    chk("id asleep", 0, oe_seen);
    send(8'hAB, 24'h0, 0, 1, 0);
    send(8'hB9, 24'h0, 0, 1, 0);
    ticks(320);
    chk("awake", 0, slp);
    chk("standby", 1, stby);
    send(8'hB9, 24'h0, 0, 1, 0);
    ticks(320);
    send(8'hAB, 24'h0, 24, 1, 16);
    chk("wake id", {16'h0, DV, DV}, rd);
    ticks(400);
    chk("waking after id", 0, stby);
    ticks(420);
    chk("standby after id", 1, stby);
  endtask
  task automatic t_ids();
    int m;
    int s;
    int w;
    for (m = 0; m < 3; m++) begin
      for (s = 0; s < 2; s++) begin
        w = 1 << m;
        send(8'h90 + 8'(2 * m), 24'(s), 24 / w, w, 16 / w);
        chk("id read", s ? {16'h0, DV, MK} : {16'h0, MK, DV}, rd);
      end
    end
  endtask
  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    fails++;
    finish_test();
  end
  initial begin
    rst_b_i <= 1'b0;
    ticks(8);
    rst_b_i <= 1'b1;
    ticks(8);
    chk("power-up standby", 1, stby);
    t_block();
    t_busy();
    t_refuse();
    t_chip();
    t_sleep();
    t_ids();
    finish_test();
  end
endmodule // fepd_core_bench
bind fepd_core fepd_core_asserts fepd_core_asserts_inst (.sys_clk_i(sys_clk_i),
  .rst_b_i(rst_b_i), .cs_b_i(cs_b_i), .write_latch_flag_i(write_latch_flag_i),
  .block_protect_bits_i(block_protect_bits_i), .io_oe_o(io_oe_o),
  .write_in_progress_flag_o(write_in_progress_flag_o), .write_latch_clr_o(write_latch_clr_o),
  .erase_go_o(erase_go_o), .erase_chip_o(erase_chip_o), .standby_o(standby_o),
  .deep_sleep_o(deep_sleep_o));

// *** testbench/fepd_host.sv ***
// host serial controller model: select, link clock and data lines
// assumes clock idle low between frames; device samples on rising edge
`timescale 1ns/1ns
module fepd_host (
  // link outputs
  output logic sclk_o,
  output logic cs_b_o,
  output logic [3:0] io_o,
  // device drive
  input wire logic [3:0] dev_io_i,
  input wire logic [3:0] dev_oe_i
);
  logic [3:0] hio;
  logic [3:0] hoe;
  // released lines show the inverse of the last value, never a stale copy
  assign io_o = (dev_oe_i & dev_io_i) | (~dev_oe_i & ~(hio ^ hoe) & 4'hF) ^ (~dev_oe_i & 4'h0);
  initial begin
    sclk_o = 1'b0;
    // scheduled so the device's select-high clear sees the first edge
    cs_b_o <= 1'b1;
    hio = 4'h0;
    hoe = 4'h0;
  end
  task automatic edge1(input logic [3:0] v);
    hio = ~(v & hoe) ^ hoe;
    #62 sclk_o = 1'b1;
    #63 sclk_o = 1'b0;
  endtask
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int nab,
      input int w, input int nrd, output logic [31:0] rd);
    int i;
    rd = 32'h0;
    cs_b_o = 1'b0;
    hoe = 4'h1;
    for (i = 7; i >= 0; i--) edge1({3'h0, op[i]});
    hoe = (w == 4) ? 4'hF : (w == 2) ? 4'h3 : 4'h1;
    for (i = nab - 1; i >= 0; i--) edge1(4'(a >> (i * w)));
    hoe = 4'h0;
    for (i = 0; i < nrd; i++) begin
      #62 sclk_o = 1'b1;
      rd = (w == 4) ? {rd[27:0], io_o} : (w == 2) ? {rd[29:0], io_o[1:0]} : {rd[30:0], io_o[1]};
      #63 sclk_o = 1'b0;
    end
    #20 cs_b_o = 1'b1;
    #100;
  endtask
endmodule // fepd_host
